/* verilog/aio_params.svh */
// Shared constants for the analog I/O range, fault and scaling logic
`ifndef AIO_PARAMS_SVH
`define AIO_PARAMS_SVH

// Widths and channel count
`define CHANNELS 4
`define SAMPLE_W 18
`define RAW_W 16
`define EU_W 32
`define ACC_W 36
`define SCL_NUM_W 67

// Raw count spans in extended sample units
`define RAW_SPAN_LO 18'sh3_8000
`define RAW_SPAN_HI 18'sh0_7FFF
`define RAW_LOOP_LO 18'sh0_1999
`define RAW_UNI_LO 18'sh0_0000

// Fault thresholds: 2.0 mA, -0.05 V at 305 uV and 153 uV, +/-5.05 V at 153 uV
`define LIM_LOOP_BREAK 18'sh0_0CCD
`define LIM_UNI10_LO 18'sh3_FF5C
`define LIM_UNI5_LO 18'sh3_FEB9
`define LIM_5V_HI 18'sh0_80EE
`define LIM_5V_LO 18'sh3_7F12

// Averaging: one filter step of 10 ms holds about 8 samples of 1.2 ms
`define FILT_SHIFT_BASE 5'h03
`define FILT_SHIFT_MAX 5'h0F

// Status byte layout and reset value
`define STATUS_UNUSED 4'h0
`define STATUS_RESET 8'h00

`endif

/* verilog/aio_pkg.sv */
// Types shared by the analog I/O range, fault and scaling logic
package aio_pkg;
  typedef enum logic [2:0] {
    RANGE_BIP_20MA = 3'h0,
    RANGE_4_20MA = 3'h1,
    RANGE_UNI_10V = 3'h2,
    RANGE_UNI_5V = 3'h3,
    RANGE_BIP_10V = 3'h4,
    RANGE_BIP_5V = 3'h5
  } range_type;

  // Per-channel setup written by the controller
  typedef struct packed {
    range_type sel_range;
    logic [15:0] filter_time;
    logic scale_en;
    logic scaled_value_limit_enable;
    logic signed [15:0] raw_min;
    logic signed [15:0] raw_max;
    logic signed [31:0] eu_min;
    logic signed [31:0] eu_max;
  } chan_cfg_type;

  typedef enum logic [1:0] {
    SCL_IDLE = 2'h0,
    SCL_DIVIDE = 2'h1,
    SCL_FINISH = 2'h2
  } scaler_state_type;

  typedef enum logic {
    SCH_LAUNCH = 1'h0,
    SCH_WAIT = 1'h1
  } sched_state_type;
endpackage

/* verilog/linear_scaler.sv */
// Sequential linear interpolation unit with rounding and optional limiting
`timescale 1ns/1ps
`default_nettype none
`include "aio_params.svh"

module linear_scaler
  import aio_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Job request, taken while idle
  input wire logic start,
  input wire logic signed [31:0] x,
  input wire logic signed [31:0] x_min,
  input wire logic signed [31:0] x_max,
  input wire logic signed [31:0] y_min,
  input wire logic signed [31:0] y_max,
  input wire logic limit_en,
  // Job result
  output logic busy_q,
  output logic done_q,
  output logic signed [31:0] y_q
);
  localparam int NW = `SCL_NUM_W;
  localparam logic signed [NW+1:0] Y_TOP = (NW+2)'(32'sh7FFF_FFFF);
  localparam logic signed [NW+1:0] Y_BOT = (NW+2)'(32'sh8000_0000);

  scaler_state_type state_q, state_d;
  logic [NW-1:0] num_q, num_d;
  logic [32:0] rem_q, rem_d;
  logic [32:0] den_q, den_d;
  logic [6:0] cnt_q, cnt_d;
  logic neg_q, neg_d, zero_q, zero_d, lim_q, lim_d, busy_d, done_d;
  logic signed [31:0] ymin_q, ymin_d, ymax_q, ymax_d, y_d;
  logic signed [32:0] dx, dy, dn;
  logic signed [NW-1:0] prod;
  logic [NW-1:0] pmag;
  logic [32:0] dmag;
  logic [34:0] trial;
  logic signed [NW+1:0] quo, sum, lo, hi;

  // Operand set-up, restoring divide and final limiting
  always_comb begin
    state_d = state_q;
    num_d = num_q;
    rem_d = rem_q;
    den_d = den_q;
    cnt_d = cnt_q;
    neg_d = neg_q;
    zero_d = zero_q;
    lim_d = lim_q;
    ymin_d = ymin_q;
    ymax_d = ymax_q;
    busy_d = busy_q;
    done_d = 1'h0;
    y_d = y_q;
    dx = 33'(x) - 33'(x_min);
    dy = 33'(y_max) - 33'(y_min);
    dn = 33'(x_max) - 33'(x_min);
    prod = NW'(dx) * NW'(dy);
    pmag = prod[NW-1] ? NW'(-prod) : NW'(prod);
    dmag = dn[32] ? 33'(-dn) : 33'(dn);
    trial = {1'h0, rem_q, num_q[NW-1]} - {2'h0, den_q};
    quo = $signed({2'h0, num_q});
    sum = (NW+2)'(ymin_q) + (neg_q ? -quo : quo);
    lo = (ymin_q <= ymax_q) ? (NW+2)'(ymin_q) : (NW+2)'(ymax_q);
    hi = (ymin_q <= ymax_q) ? (NW+2)'(ymax_q) : (NW+2)'(ymin_q);
    unique case (state_q)
      SCL_IDLE: begin
        if (start) begin
          // Half the divisor added first rounds to nearest
          num_d = pmag + NW'(dmag >> 1);
          den_d = dmag;
          rem_d = '0;
          neg_d = prod[NW-1] ^ dn[32];
          zero_d = (dn == '0);
          ymin_d = y_min;
          ymax_d = y_max;
          lim_d = limit_en;
          cnt_d = 7'(NW - 1);
          busy_d = 1'h1;
          state_d = SCL_DIVIDE;
        end
      end
      SCL_DIVIDE: begin
        if (trial[34]) begin
          rem_d = {rem_q[31:0], num_q[NW-1]};
          num_d = {num_q[NW-2:0], 1'h0};
        end else begin
          rem_d = trial[32:0];
          num_d = {num_q[NW-2:0], 1'h1};
        end
        cnt_d = cnt_q - 7'h01;
        if (cnt_q == 7'h00) begin
          state_d = SCL_FINISH;
        end
      end
      SCL_FINISH: begin
        // RULE16 rounded interpolation
        if (zero_q) begin
          sum = (NW+2)'(ymin_q);
        end
        // RULE14 hold to endpoints
        if (lim_q && sum < lo) begin
          sum = lo;
        end
        if (lim_q && sum > hi) begin
          sum = hi;
        end
        if (sum > Y_TOP) begin
          y_d = 32'sh7FFF_FFFF;
        end else if (sum < Y_BOT) begin
          y_d = 32'sh8000_0000;
        end else begin
          y_d = sum[31:0];
        end
        done_d = 1'h1;
        busy_d = 1'h0;
        state_d = SCL_IDLE;
      end
      default: state_d = SCL_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= SCL_IDLE;
      num_q <= '0;
      rem_q <= '0;
      den_q <= '0;
      cnt_q <= '0;
      neg_q <= 1'h0;
      zero_q <= 1'h0;
      lim_q <= 1'h0;
      ymin_q <= '0;
      ymax_q <= '0;
      busy_q <= 1'h0;
      done_q <= 1'h0;
      y_q <= '0;
    end else begin
      state_q <= state_d;
      num_q <= num_d;
      rem_q <= rem_d;
      den_q <= den_d;
      cnt_q <= cnt_d;
      neg_q <= neg_d;
      zero_q <= zero_d;
      lim_q <= lim_d;
      ymin_q <= ymin_d;
      ymax_q <= ymax_d;
      busy_q <= busy_d;
      done_q <= done_d;
      y_q <= y_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  limit_hold_a: assert property (done_q && lim_q |-> // RULE14
    ((ymin_q <= ymax_q) ? (y_q >= ymin_q && y_q <= ymax_q)
                        : (y_q >= ymax_q && y_q <= ymin_q)))
    else $error("limited result outside endpoints");
  end_low_a: assert property (start && !busy_q && x == x_min && x_max != x_min // RULE16
    |=> ##[0:72] (done_q && y_q == ymin_q))
    else $error("low endpoint not mapped exactly");
  end_high_a: assert property (start && !busy_q && x == x_max && x_max != x_min // RULE13
    |=> ##[0:72] (done_q && y_q == ymax_q))
    else $error("high endpoint not mapped exactly");
  limit_hit_c: cover property (done_q && lim_q && y_q == ymax_q);
endmodule
`default_nettype wire

/* verilog/analog_io_range_and_fault_logic.sv */
// Analog I/O raw encoding, fault flags, averaging and scaling
`timescale 1ns/1ps
`default_nettype none
`include "aio_params.svh"

// Functional notes
// RULE1: Outputs get all 16 bits only in bipolar ranges; unipolar ones drop the lowest bit.
// RULE2: The -20..20 mA range codes -32768..32767 and 4..20 mA codes 6553..32767.
// RULE3: The 0..10 V and 0..5 V ranges code 0..32767.
// RULE4: The +/-10 V and +/-5 V ranges code the full signed range -32768..32767.
// RULE5: The fault byte sits in the controller's first free aligned input byte.
// RULE6: Fault byte bits 0..3 belong to inputs 1..4 and bits 4..7 read zero.
// RULE7: In -20..20 mA a channel faults below -20 mA or above 20 mA.
// RULE8: In 4..20 mA a channel faults only below 2 mA, a broken loop.
// RULE9: In 0..10 V a channel faults below -0.05 V or above 10 V.
// RULE10: In 0..5 V a channel faults below -0.05 V or above 5.05 V.
// RULE11: The +/-10 V range faults beyond 10 V and +/-5 V beyond 5.05 V.
// RULE12: Each input averages over its filter time, and a time of zero disables it.
// RULE13: With scaling on, the raw input maps linearly from raw limits to unit limits.
// RULE14: With limiting on, the scaled value stays between the unit limits.
// RULE15: With scaling on, an output value maps from unit limits to raw limits.
// RULE16: Scaling interpolates between the endpoints and rounds to nearest.
module analog_io_range_and_fault_logic
  import aio_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Converter samples, one strobe for all inputs
  input wire logic sample_valid,
  input wire logic [`CHANNELS-1:0][`SAMPLE_W-1:0] in_sample,
  // Channel setup from the controller
  input wire chan_cfg_type [`CHANNELS-1:0] in_cfg,
  input wire chan_cfg_type [`CHANNELS-1:0] out_cfg,
  // Output values from the controller
  input wire logic [`CHANNELS-1:0][`EU_W-1:0] scaled_output_value,
  input wire logic [`CHANNELS-1:0][`RAW_W-1:0] direct_output_word,
  // Input results
  output logic [`CHANNELS-1:0][`RAW_W-1:0] raw_input_word_q,
  output logic [`CHANNELS-1:0][`EU_W-1:0] scaled_input_value_q,
  output logic [7:0] input_fault_status_byte_q,
  // Output results
  output logic [`CHANNELS-1:0][`RAW_W-1:0] raw_output_word_q,
  output logic [`CHANNELS-1:0][`RAW_W-1:0] dac_code_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // RULE3 RULE4 clamp into range span
  function automatic logic [15:0] span_clamp(input range_type r,
                                             input logic signed [17:0] v);
    logic signed [17:0] lo;
    logic signed [17:0] hi;
    lo = `RAW_SPAN_LO;
    hi = `RAW_SPAN_HI;
    if (r == RANGE_4_20MA) begin
      lo = `RAW_LOOP_LO;
    end else if (r == RANGE_UNI_10V || r == RANGE_UNI_5V) begin
      lo = `RAW_UNI_LO;
    end
    if (v < lo) begin
      return lo[15:0];
    end
    if (v > hi) begin
      return hi[15:0];
    end
    return v[15:0];
  endfunction

  // RULE8 RULE9 RULE10 RULE11 fault test; unknown code faults
  function automatic logic input_fault_status_byte(input range_type r,
                                        input logic signed [17:0] v);
    logic f;
    case (r)
      RANGE_BIP_20MA, RANGE_BIP_10V: f = v < `RAW_SPAN_LO || v > `RAW_SPAN_HI;
      RANGE_4_20MA: f = v < `LIM_LOOP_BREAK;
      RANGE_UNI_10V: f = v < `LIM_UNI10_LO || v > `RAW_SPAN_HI;
      RANGE_UNI_5V: f = v < `LIM_UNI5_LO || v > `LIM_5V_HI;
      RANGE_BIP_5V: f = v < `LIM_5V_LO || v > `LIM_5V_HI;
      default: f = 1'h1;
    endcase
    return f;
  endfunction

  // Averaging shift from a filter time in 10 ms steps
  function automatic logic [4:0] filt_shift(input logic [15:0] ft);
    logic [4:0] s;
    s = 5'h00;
    for (int b = 0; b < 16; b++) begin
      if (ft[b]) begin
        s = 5'(b + 1);
      end
    end
    if (ft == 16'h0000) begin
      return 5'h00;
    end
    s = s + `FILT_SHIFT_BASE;
    return (s > `FILT_SHIFT_MAX) ? `FILT_SHIFT_MAX : s;
  endfunction

  function automatic logic is_unipolar(input range_type r);
    return r == RANGE_4_20MA || r == RANGE_UNI_10V || r == RANGE_UNI_5V;
  endfunction

  wire logic [`CHANNELS-1:0][`RAW_W-1:0] raw_d;
  wire logic [`CHANNELS-1:0] flag_d;
  logic [7:0] status_d;

  // Per-channel averaging, raw encoding and fault test
  for (genvar i = 0; i < `CHANNELS; i++) begin : g_in
    logic signed [`ACC_W-1:0] acc_q, acc_d, tgt, diff;
    logic signed [`SAMPLE_W-1:0] smp, avg;
    logic [4:0] sh;
    logic [`RAW_W-1:0] raw_c;
    logic flag_c;

    // RULE12 running average
    always_comb begin
      smp = in_sample[i];
      sh = filt_shift(in_cfg[i].filter_time);
      tgt = {{2{smp[17]}}, smp, 16'h0000};
      diff = tgt - acc_q;
      acc_d = acc_q;
      if (sample_valid) begin
        acc_d = (sh == 5'h00) ? tgt : acc_q + (diff >>> sh);
      end
      avg = acc_d[33:16];
      raw_c = raw_input_word_q[i];
      flag_c = input_fault_status_byte_q[i];
      if (sample_valid) begin
        // RULE2 span by range
        raw_c = span_clamp(in_cfg[i].sel_range, avg);
        // RULE7 fault on the live sample
        flag_c = input_fault_status_byte(in_cfg[i].sel_range, smp);
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        acc_q <= '0;
      end else begin
        acc_q <= acc_d;
      end
    end

    assign raw_d[i] = raw_c;
    assign flag_d[i] = flag_c;

    fault_bip20_a: assert property (sample_valid // RULE7
      && in_cfg[i].sel_range == RANGE_BIP_20MA
      && (smp < `RAW_SPAN_LO || smp > `RAW_SPAN_HI)
      |=> input_fault_status_byte_q[i])
      else $error("current fault not flagged");
    fault_loop_a: assert property (sample_valid // RULE8
      && in_cfg[i].sel_range == RANGE_4_20MA && smp >= `LIM_LOOP_BREAK
      |=> !input_fault_status_byte_q[i])
      else $error("loop range flagged above break level");
    fault_uni10_a: assert property (sample_valid // RULE9
      && in_cfg[i].sel_range == RANGE_UNI_10V
      && (smp < `LIM_UNI10_LO || smp > `RAW_SPAN_HI)
      |=> input_fault_status_byte_q[i])
      else $error("0-10 V fault not flagged");
    fault_uni5_a: assert property (sample_valid // RULE10
      && in_cfg[i].sel_range == RANGE_UNI_5V
      && (smp < `LIM_UNI5_LO || smp > `LIM_5V_HI)
      |=> input_fault_status_byte_q[i])
      else $error("0-5 V fault not flagged");
    fault_bip5_a: assert property (sample_valid // RULE11
      && in_cfg[i].sel_range == RANGE_BIP_5V
      && smp >= `LIM_5V_LO && smp <= `LIM_5V_HI
      |=> !input_fault_status_byte_q[i])
      else $error("bipolar 5 V flagged inside limits");
    raw_loop_a: assert property (sample_valid // RULE2
      && in_cfg[i].sel_range == RANGE_4_20MA
      |=> $signed(raw_input_word_q[i]) >= 16'sh1999)
      else $error("loop raw below span");
    raw_uni_a: assert property (sample_valid // RULE3
      && (in_cfg[i].sel_range == RANGE_UNI_10V || in_cfg[i].sel_range == RANGE_UNI_5V)
      |=> !raw_input_word_q[i][15])
      else $error("unipolar raw negative");
    raw_bip_a: assert property (sample_valid && in_cfg[i].filter_time == 16'h0000 // RULE4
      && in_cfg[i].sel_range == RANGE_BIP_10V && smp < `RAW_SPAN_LO
      |=> raw_input_word_q[i] == 16'h8000)
      else $error("bipolar raw not at negative end");
    no_filter_a: assert property (sample_valid && in_cfg[i].filter_time == 16'h0000 // RULE12
      && in_cfg[i].sel_range == RANGE_BIP_5V
      && smp >= `RAW_SPAN_LO && smp <= `RAW_SPAN_HI
      |=> raw_input_word_q[i] == $past(smp[15:0]))
      else $error("unfiltered raw differs from sample");
  end

  // RULE6 flags in the low nibble
  assign status_d = {`STATUS_UNUSED, flag_d};

  // RULE5 result registers, byte to controller
  always_ff @(posedge clock) begin
    if (rst) begin
      raw_input_word_q <= '0;
      input_fault_status_byte_q <= `STATUS_RESET;
    end else begin
      raw_input_word_q <= raw_d;
      input_fault_status_byte_q <= status_d;
    end
  end

  // Shared scaler, visited round robin: jobs 0-3 inputs, 4-7 outputs
  sched_state_type sch_q, sch_d;
  logic [2:0] job_q, job_d;
  logic start_q, start_d;
  logic busy, done;
  logic signed [31:0] y, sx, sx_min, sx_max, sy_min, sy_max;
  logic lim;
  logic [1:0] ch;
  logic is_out;
  logic signed [17:0] word_x;
  logic [15:0] word, span;
  chan_cfg_type cfg;
  logic [`CHANNELS-1:0][`EU_W-1:0] scaled_d;
  logic [`CHANNELS-1:0][`RAW_W-1:0] raw_out_d, dac_d;

  // Operand select and result write-back
  always_comb begin
    ch = job_q[1:0];
    is_out = job_q[2];
    cfg = is_out ? out_cfg[ch] : in_cfg[ch];
    sch_d = sch_q;
    job_d = job_q;
    start_d = 1'h0;
    scaled_d = scaled_input_value_q;
    raw_out_d = raw_output_word_q;
    dac_d = dac_code_q;
    lim = cfg.scaled_value_limit_enable;
    if (is_out) begin
      // RULE15 units to raw
      sx = $signed(scaled_output_value[ch]);
      sx_min = cfg.eu_min;
      sx_max = cfg.eu_max;
      sy_min = 32'(cfg.raw_min);
      sy_max = 32'(cfg.raw_max);
    end else begin
      // RULE13 raw to units
      sx = 32'($signed(raw_input_word_q[ch]));
      sx_min = 32'(cfg.raw_min);
      sx_max = 32'(cfg.raw_max);
      sy_min = cfg.eu_min;
      sy_max = cfg.eu_max;
    end
    word = direct_output_word[ch];
    if (cfg.scale_en) begin
      word = (y > 32'sh0000_7FFF) ? 16'h7FFF
           : (y < -32'sh0000_8000) ? 16'h8000 : y[15:0];
    end
    word_x = 18'($signed(word));
    span = span_clamp(cfg.sel_range, word_x);
    unique case (sch_q)
      SCH_LAUNCH: begin
        start_d = 1'h1;
        sch_d = SCH_WAIT;
      end
      SCH_WAIT: begin
        if (done) begin
          if (is_out) begin
            raw_out_d[ch] = span;
            // RULE1 unipolar loses the lowest bit
            dac_d[ch] = is_unipolar(cfg.sel_range) ? {span[14:0], 1'h0} : span;
          end else begin
            scaled_d[ch] = cfg.scale_en ? y : 32'($signed(raw_input_word_q[ch]));
          end
          job_d = job_q + 3'h1;
          sch_d = SCH_LAUNCH;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sch_q <= SCH_LAUNCH;
      job_q <= 3'h0;
      start_q <= 1'h0;
      scaled_input_value_q <= '0;
      raw_output_word_q <= '0;
      dac_code_q <= '0;
    end else begin
      sch_q <= sch_d;
      job_q <= job_d;
      start_q <= start_d;
      scaled_input_value_q <= scaled_d;
      raw_output_word_q <= raw_out_d;
      dac_code_q <= dac_d;
    end
  end

  linear_scaler u_scaler (
    .clock(clock),
    .rst(rst),
    .start(start_q),
    .x(sx),
    .x_min(sx_min),
    .x_max(sx_max),
    .y_min(sy_min),
    .y_max(sy_max),
    .limit_en(lim),
    .busy_q(busy),
    .done_q(done),
    .y_q(y)
  );

  status_hi_a: assert property (sample_valid |=> // RULE6
    input_fault_status_byte_q[7:4] == 4'h0 && input_fault_status_byte_q[3:0] == $past(flag_d))
    else $error("status byte layout wrong");
  job_turn_a: assert property (start_q |-> ##[1:72] done) // RULE15
    else $error("scaling job did not finish");
  launch_idle_a: assert property (start_q |-> !busy) // RULE13
    else $error("scaling job launched while busy");
  dac_lsb_a: assert property (sch_q == SCH_WAIT && done && is_out // RULE1
    && is_unipolar(cfg.sel_range) |=> dac_code_q[$past(ch)][0] == 1'h0)
    else $error("unipolar output kept lowest bit");
  fault_seen_c: cover property (sample_valid ##1 input_fault_status_byte_q[0]);
  loop_break_c: cover property (sample_valid && in_cfg[1].sel_range == RANGE_4_20MA
    && $signed(in_sample[1]) < `LIM_LOOP_BREAK);
  out_done_c: cover property (sch_q == SCH_WAIT && done && job_q == 3'h7);
endmodule
`default_nettype wire

/* tb/aio_controller_model.sv */
// Controller-side model that maps the fault byte into its input image
`timescale 1ns/1ps
`default_nettype none
module aio_controller_model #(
  parameter int FREE_BIT = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fault byte from the module
  input wire logic [7:0] status_byte,
  // Controller input image
  output logic [31:0] input_image_q
);
  always_ff @(posedge clock) begin
    if (rst) begin
      input_image_q <= 32'h0000_0000;
    end else begin
      input_image_q[FREE_BIT+:8] <= status_byte;
    end
  end
endmodule
`default_nettype wire

/* tb/analog_io_range_and_fault_logic_tb_top.sv */
// Self-checking bench for the analog I/O range, fault and scaling logic
`timescale 1ns/1ps
`default_nettype none
`include "aio_params.svh"
module analog_io_range_and_fault_logic_tb_top
  import aio_pkg::*;
;
  logic clock, rst, sample_valid;
  logic [`CHANNELS-1:0][`SAMPLE_W-1:0] in_sample;
  chan_cfg_type [`CHANNELS-1:0] in_cfg, out_cfg;
  logic [`CHANNELS-1:0][`EU_W-1:0] scaled_output_value, scaled_input_value_q;
  logic [`CHANNELS-1:0][`RAW_W-1:0] direct_output_word, raw_input_word_q;
  logic [`CHANNELS-1:0][`RAW_W-1:0] raw_output_word_q, dac_code_q;
  logic [7:0] input_fault_status_byte_q;
  logic [31:0] input_image_q;
  int fails = 0;
  int num_checks = 0;
  int lo_e[8] = '{-32768, 3277, -164, -327, -32768, -33006, 0, 0};
  int hi_e[8] = '{32767, 100000, 32767, 33006, 32767, 33006, 0, 0};
  logic [7:0] fwd[8] = '{8'h0A, 8'h02, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0F, 8'h0F};
  logic [7:0] rev[8] = '{8'h05, 8'h04, 8'h05, 8'h05, 8'h05, 8'h05, 8'h0F, 8'h0F};

  analog_io_range_and_fault_logic analog_io_range_and_fault_logic_inst (
    .clock(clock), .rst(rst), .sample_valid(sample_valid), .in_sample(in_sample),
    .in_cfg(in_cfg), .out_cfg(out_cfg), .scaled_output_value(scaled_output_value),
    .direct_output_word(direct_output_word), .raw_input_word_q(raw_input_word_q),
    .scaled_input_value_q(scaled_input_value_q),
    .input_fault_status_byte_q(input_fault_status_byte_q),
    .raw_output_word_q(raw_output_word_q), .dac_code_q(dac_code_q)
  );

  aio_controller_model aio_controller_model_inst (
    .clock(clock), .rst(rst), .status_byte(input_fault_status_byte_q),
    .input_image_q(input_image_q)
  );

  // Clock generation
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Compare one value
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One sample strobe for all inputs, raw words and fault byte settled on return
  task automatic apply(input int s[4]);
    @(posedge clock);
    sample_valid <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      in_sample[i] <= s[i][17:0];
    end
    @(posedge clock);
    sample_valid <= 1'b0;
    #1;
  endtask

  // Expected raw count after the span clamp of a range
  function automatic logic [15:0] span(input int r, input int s);
    int lo;
    lo = (r == 1) ? 6553 : (r == 2 || r == 3) ? 0 : -32768;
    if (s < lo) return lo[15:0];
    if (s > 32767) return 16'h7FFF;
    return s[15:0];
  endfunction

  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    results();
  end

  initial begin
    int s[4];
    rst = 1'b1;
    sample_valid = 1'b0;
    in_sample = '0;
    in_cfg = '0;
    out_cfg = '0;
    scaled_output_value = '0;
    direct_output_word = '0;
    repeat (10) @(posedge clock);
    #1;
    check("status in reset", {24'h0, input_fault_status_byte_q}, 32'h0); // cleared byte
    check("raw in reset", {16'h0, raw_input_word_q[0]}, 32'h0); // cleared word
    @(posedge clock);
    rst <= 1'b0;
    // Threshold edges of every range, both channel orders
    for (int r = 0; r < 8; r++) begin
      @(posedge clock);
      for (int i = 0; i < 4; i++) begin
        in_cfg[i].sel_range <= range_type'(r);
      end
      s = '{lo_e[r], lo_e[r] - 1, hi_e[r], hi_e[r] + 1};
      apply(s);
      check("status fwd", {24'h0, input_fault_status_byte_q}, fwd[r]); // edges
      for (int i = 0; i < 4; i++) begin
        check("raw span", {16'h0, raw_input_word_q[i]}, span(r, s[i])); // spans
      end
      apply('{s[3], s[2], s[1], s[0]});
      check("status rev", {24'h0, input_fault_status_byte_q}, rev[r]); // bit order
      @(posedge clock);
      #1;
      check("image byte", {24'h0, input_image_q[23:16]}, rev[r]); // mapped byte
    end
    // Averaging on channel 0
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      in_cfg[i].sel_range <= RANGE_BIP_10V;
    end
    in_cfg[0].filter_time <= 16'h0001;
    repeat (300) apply('{0, 0, 0, 0});
    check("avg zero", {31'h0, $signed(raw_input_word_q[0]) inside {[-2:2]}}, 32'h1); // settles
    apply('{40000, 0, 0, 0});
    check("avg step", {31'h0, $signed(raw_input_word_q[0]) inside {[1:15999]}}, 32'h1); // smoothing
    check("flag unfiltered", {24'h0, input_fault_status_byte_q}, 32'h1); // raw sample
    repeat (300) apply('{16000, 0, 0, 0});
    check("avg level", {31'h0, $signed(raw_input_word_q[0]) inside {[15998:16002]}}, 32'h1); // settles
    @(posedge clock);
    in_cfg[0].filter_time <= 16'h0000;
    apply('{100, 0, 0, 0});
    check("avg off", {16'h0, raw_input_word_q[0]}, 32'h64); // zero disables
    // Input and output scaling setup
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      in_cfg[i].sel_range <= RANGE_BIP_10V;
      in_cfg[i].scale_en <= (i != 3);
      in_cfg[i].scaled_value_limit_enable <= (i == 2);
      in_cfg[i].raw_min <= 16'sh0000;
      in_cfg[i].raw_max <= 16'sh0004;
      in_cfg[i].eu_min <= 32'sh0000_0000;
      in_cfg[i].eu_max <= 32'sh0000_000A;
    end
    out_cfg[0].sel_range <= RANGE_BIP_10V;
    out_cfg[0].scale_en <= 1'b1;
    out_cfg[0].raw_max <= 16'sh7FFF;
    out_cfg[0].eu_max <= 32'sh0000_0064;
    scaled_output_value[0] <= 32'h0000_0032;
    out_cfg[1].sel_range <= RANGE_UNI_10V;
    direct_output_word[1] <= 16'h1235;
    out_cfg[2].sel_range <= RANGE_BIP_5V;
    direct_output_word[2] <= 16'hFFFB;
    out_cfg[3].sel_range <= RANGE_UNI_5V;
    direct_output_word[3] <= 16'hFFFF;
    apply('{1, 8, 8, -4});
    repeat (1200) @(posedge clock);
    #1;
    check("scale round", scaled_input_value_q[0], 32'h0000_0003); // half rounds up
    check("scale extrap", scaled_input_value_q[1], 32'h0000_0014); // beyond limits
    check("scale clamp", scaled_input_value_q[2], 32'h0000_000A); // held at max
    check("scale off", scaled_input_value_q[3], 32'hFFFF_FFFC); // raw passed
    check("out scaled", {16'h0, raw_output_word_q[0]}, 32'h4000); // rounded
    check("out direct", {16'h0, raw_output_word_q[1]}, 32'h1235); // in span
    check("out bipolar", {16'h0, raw_output_word_q[2]}, 32'hFFFB); // negative kept
    check("out clip", {16'h0, raw_output_word_q[3]}, 32'h0); // floor at zero
    check("dac bip", {16'h0, dac_code_q[0]}, 32'h4000); // full width
    check("dac uni", {16'h0, dac_code_q[1]}, 32'h246A); // drops lowest bit
    check("dac neg", {16'h0, dac_code_q[2]}, 32'hFFFB); // full width
    check("dac floor", {16'h0, dac_code_q[3]}, 32'h0); // unipolar zero
    // Reset in mid-run clears results, then sampling resumes
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check("status mid reset", {24'h0, input_fault_status_byte_q}, 32'h0); // cleared byte
    check("scaled mid reset", scaled_input_value_q[1], 32'h0); // cleared value
    @(posedge clock);
    rst <= 1'b0;
    apply('{40000, 0, 0, 0});
    check("status after reset", {24'h0, input_fault_status_byte_q}, 32'h1); // first sample
    check("raw after reset", {16'h0, raw_input_word_q[0]}, 32'h7FFF); // top of span
    results();
  end
endmodule
`default_nettype wire
